// ===== tb/mcr_host_model.sv
// Host model: issues one-cycle register accesses on the decoded request port.
// Assumes the testbench calls its task and nothing else drives the request.
`timescale 1ns/100ps
`default_nettype none
module mcr_host_model (
    input  wire logic         ref_clk_i,
    input  wire logic [23:0]  rdata_i,
    output mcr_pkg::mcr_req_s req_o
);
    // Mode register and soft reset live outside this map, so none is issued
    initial req_o = '0;

    // One access: strobe for one cycle, take the answer, then scramble idle fields
    task automatic acc(input logic w, input logic [7:0] a, input logic [23:0] d,
                       output logic [23:0] q);
        @(negedge ref_clk_i);
        req_o = {w, ~w, a, d};
        @(negedge ref_clk_i);
        q = rdata_i;
        req_o = {2'b00, ~a, ~d};
    endtask : acc
endmodule : mcr_host_model
`default_nettype wire

// ===== tb/meter_calibration_register_tail_test.sv
// Testbench for the calibration register tail: register access and correction datapath.
// Assumes the host model drives requests and the bench drives the raw phase values.
`timescale 1ns/100ps
`default_nettype none
module meter_calibration_register_tail_test;
    logic                ref_clk_i = 1'b0;
    logic                rst_b_i   = 1'b0;
    mcr_pkg::mcr_req_s   req;
    logic [11:0]         ab_os     = 12'h000;
    logic [23:0]         rdata;
    logic                rvalid;
    mcr_pkg::mcr_phase_s raw [3]   = '{default: '0};
    mcr_pkg::mcr_phase_s cal [3];
    logic [11:0]         g [10];
    logic [23:0]         q;
    logic [7:0]          last      = 8'h00;
    int                  err_count = 0;
    int                  checked   = 0;
    int                  cyc       = 0;

    always #2 ref_clk_i = ~ref_clk_i;

    mcr_reg_tail mcr_reg_tail_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .req_i(req),
        .ab_irms_os_i(ab_os), .rdata_o(rdata), .rvalid_o(rvalid), .raw_a_i(raw[0]),
        .raw_b_i(raw[1]), .raw_c_i(raw[2]), .cal_a_o(cal[0]), .cal_b_o(cal[1]),
        .cal_c_o(cal[2]));
    mcr_host_model mcr_host_model_i (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .req_o(req));

    // Verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask : chk

    // Read one register and keep the ones count of the expected value
    task automatic rd(input logic [7:0] a, input logic [23:0] e);
        mcr_host_model_i.acc(1'b0, a, 24'($urandom), q);
        chk("rdata", e, q);
        chk("rvalid", 24'h1, {23'h0, rvalid});
        last = 8'($countones(e));
    endtask : rd

    // Gain factor is one plus the signed value over 4096, truncated to 24 bits
    function automatic logic [23:0] scale(input logic [23:0] r, input logic [11:0] gg);
        longint p;
        p = longint'($signed(r)) * (64'sd4096 + longint'($signed(gg)));
        return p[35:12];
    endfunction : scale

    function automatic logic [23:0] ofs(input logic [23:0] r, input logic [11:0] o);
        return r + {{12{o[11]}}, o};
    endfunction : ofs

    // Cycle ceiling against a hang
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            close_out();
        end
    end

    initial begin
        q = $urandom(32'hd768b83c);
        repeat (20) @(negedge ref_clk_i);
        rst_b_i = 1'b1;
        // Reset values, then writes aimed at read-only and reserved places
        for (int i = 0; i < 10; i++) rd(8'h31 + 8'(i), 24'h0);
        rd(mcr_pkg::ADDR_ONES_CNT, 24'h0);
        mcr_host_model_i.acc(1'b1, mcr_pkg::ADDR_DIE_REV, 24'($urandom), q);
        mcr_host_model_i.acc(1'b1, mcr_pkg::ADDR_ONES_CNT, 24'($urandom), q);
        mcr_host_model_i.acc(1'b1, 8'h3b, 24'($urandom), q);
        rd(8'h3b, 24'h0);
        rd(mcr_pkg::ADDR_DIE_REV, {16'h0, mcr_pkg::DIE_REV_DEFAULT});
        rd(mcr_pkg::ADDR_ONES_CNT, {16'h0, last});
        // Rounds: most negative gain, most positive gain, then random values
        for (int r = 0; r < 4; r++) begin
            for (int i = 0; i < 10; i++) begin
                g[i] = (r == 0) ? 12'h800 : (r == 1) ? 12'h7ff : 12'($urandom);
                mcr_host_model_i.acc(1'b1, 8'h31 + 8'(i), {12'($urandom), g[i]}, q);
            end
            for (int i = 0; i < 10; i++) begin
                rd(8'h31 + 8'(i), {12'h0, g[i]});
                rd(mcr_pkg::ADDR_ONES_CNT, {16'h0, last});
            end
            ab_os = 12'($urandom);
            for (int p = 0; p < 3; p++) begin
                raw[p] = {24'($urandom), 24'($urandom), 24'($urandom), 24'($urandom)};
            end
            repeat (3) @(negedge ref_clk_i);
            for (int p = 0; p < 3; p++) begin
                chk("active", scale(raw[p].active_pwr, g[4+p]), cal[p].active_pwr);
                chk("apparent", scale(raw[p].apparent_pwr, g[7+p]), cal[p].apparent_pwr);
                chk("vrms", ofs(raw[p].vrms, g[1+p]), cal[p].vrms);
                chk("irms", ofs(raw[p].irms, (p == 2) ? g[0] : ab_os), cal[p].irms);
            end
        end
        close_out();
    end
endmodule : meter_calibration_register_tail_test
`default_nettype wire

// ===== verilog/mcr_phase_cal.sv
// One phase of gain and offset correction.
// Assumes inputs are stable samples from the metering datapath.
`timescale 1ns/100ps
`default_nettype none
module mcr_phase_cal (
    input  wire logic                ref_clk_i,
    input  wire logic                rst_b_i,
    input  wire mcr_pkg::mcr_phase_s raw_i,
    input  wire logic [11:0]         ap_gain_i,
    input  wire logic [11:0]         v_gain_i,
    input  wire logic [11:0]         i_os_i,
    input  wire logic [11:0]         v_os_i,
    output mcr_pkg::mcr_phase_s      cal_o
);
    // ----------------------------------------------------------------
    // Scaling
    // ----------------------------------------------------------------
    // Gain as signed factor, offsets sign extended
    wire logic signed [37:0] ap_prod;
    wire logic signed [37:0] va_prod;
    wire logic signed [23:0] i_sum;
    wire logic signed [23:0] v_sum;
    assign ap_prod = 38'(raw_i.active_pwr * $signed({1'b0, 13'h1000} + {{2{ap_gain_i[11]}}, ap_gain_i}));
    assign va_prod = 38'(raw_i.apparent_pwr * $signed({1'b0, 13'h1000} + {{2{v_gain_i[11]}}, v_gain_i}));
    assign i_sum   = raw_i.irms + 24'($signed(i_os_i));
    assign v_sum   = raw_i.vrms + 24'($signed(v_os_i));

    // Registered corrected results
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cal_o <= '0;
        end else begin
            cal_o.active_pwr   <= ap_prod[mcr_pkg::GAIN_SHIFT +: mcr_pkg::RD_W];
            cal_o.apparent_pwr <= va_prod[mcr_pkg::GAIN_SHIFT +: mcr_pkg::RD_W];
            cal_o.irms         <= i_sum;
            cal_o.vrms         <= v_sum;
        end
    end
endmodule : mcr_phase_cal
`default_nettype wire

// ===== verilog/mcr_pkg.sv
// Package for the calibration register tail of the energy meter.
// Assumes a host serial port front end that presents decoded register accesses.
package mcr_pkg;

    // ----------------------------------------------------------------
    // Register indices
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_C_IRMS_OS = 8'h31;
    localparam logic [7:0] ADDR_A_VRMS_OS = 8'h32;
    localparam logic [7:0] ADDR_B_VRMS_OS = 8'h33;
    localparam logic [7:0] ADDR_C_VRMS_OS = 8'h34;
    localparam logic [7:0] ADDR_A_AP_GAIN = 8'h35;
    localparam logic [7:0] ADDR_B_AP_GAIN = 8'h36;
    localparam logic [7:0] ADDR_C_AP_GAIN = 8'h37;
    localparam logic [7:0] ADDR_A_V_GAIN  = 8'h38;
    localparam logic [7:0] ADDR_B_V_GAIN  = 8'h39;
    localparam logic [7:0] ADDR_C_V_GAIN  = 8'h3a;
    localparam logic [7:0] ADDR_ONES_CNT  = 8'h3e;
    localparam logic [7:0] ADDR_DIE_REV   = 8'h3f;

    // ----------------------------------------------------------------
    // Widths and reset values
    // ----------------------------------------------------------------
    localparam int         CAL_W       = 12;
    localparam int         RD_W        = 24;
    localparam int         CNT_W       = 8;
    localparam logic [11:0] CAL_RESET  = 12'h000;
    localparam logic [7:0]  CNT_RESET  = 8'h00;
    localparam int         GAIN_SHIFT  = 12;  // Gain is 1 + value/4096
    localparam logic [7:0]  DIE_REV_DEFAULT = 8'h5a;  // Arbitrary value

    // Register access as seen from the serial port front end
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [RD_W-1:0] wdata;
    } mcr_req_s;

    // Accumulated values into and scaled values out of one phase
    typedef struct packed {
        logic signed [RD_W-1:0] active_pwr;
        logic signed [RD_W-1:0] apparent_pwr;
        logic signed [RD_W-1:0] irms;
        logic signed [RD_W-1:0] vrms;
    } mcr_phase_s;

endpackage : mcr_pkg

// ===== verilog/mcr_reg_tail.sv
// Calibration register tail: offsets, gains, ones count and die revision.
// Assumes a serial port front end delivering one-cycle read and write strobes.
//
// How it works
// - The ones count register holds the number of set bits of the last value read out.
// - Each phase's active power is scaled by its own 12-bit gain register.
// - Each phase's apparent power is scaled by its own 12-bit voltage rms gain register.
// - Each phase's voltage rms gets a 12-bit offset that resets to zero; so does phase C current rms, while A and B take ab_irms_os_i.
// - Read-only registers ignore writes and writable registers take both.
`timescale 1ns/100ps
`default_nettype none
module mcr_reg_tail (
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_b_i,
    input  wire mcr_pkg::mcr_req_s     req_i,
    input  wire logic [11:0]           ab_irms_os_i,
    output logic [23:0]                rdata_o,
    output logic                       rvalid_o,
    input  wire mcr_pkg::mcr_phase_s   raw_a_i,
    input  wire mcr_pkg::mcr_phase_s   raw_b_i,
    input  wire mcr_pkg::mcr_phase_s   raw_c_i,
    output mcr_pkg::mcr_phase_s        cal_a_o,
    output mcr_pkg::mcr_phase_s        cal_b_o,
    output mcr_pkg::mcr_phase_s        cal_c_o
);
    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [11:0] cal_reg [10];   // Index = addr - 0x31
    logic [7:0]  ones_count;
    logic [7:0]  die_revision;

    // Write decode for writable window only
    wire logic       in_cal;
    wire logic [3:0] cal_idx;
    assign in_cal  = (req_i.addr >= mcr_pkg::ADDR_C_IRMS_OS) &&
                     (req_i.addr <= mcr_pkg::ADDR_C_V_GAIN);
    assign cal_idx = 4'(req_i.addr - mcr_pkg::ADDR_C_IRMS_OS);

    // Writable registers take host writes
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int k = 0; k < 10; k++) cal_reg[k] <= mcr_pkg::CAL_RESET;
        end else if (req_i.wr && in_cal) begin
            cal_reg[cal_idx] <= req_i.wdata[11:0];
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    logic [23:0] next_rdata;
    always_comb begin
        next_rdata = '0;
        if (in_cal) next_rdata = {12'h000, cal_reg[cal_idx]};
        else if (req_i.addr == mcr_pkg::ADDR_ONES_CNT) next_rdata = {16'h0000, ones_count};
        else if (req_i.addr == mcr_pkg::ADDR_DIE_REV) next_rdata = {16'h0000, die_revision};
    end

    // Count of set bits in the outgoing word
    logic [7:0] next_ones;
    always_comb begin
        next_ones = '0;
        for (int k = 0; k < 24; k++) next_ones = next_ones + 8'(next_rdata[k]);
    end

    // Read data, ones count capture, die revision constant
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o      <= '0;
            rvalid_o     <= 1'b0;
            ones_count   <= mcr_pkg::CNT_RESET;
            die_revision <= mcr_pkg::DIE_REV_DEFAULT;
        end else begin
            rvalid_o <= req_i.rd;
            if (req_i.rd) begin
                rdata_o    <= next_rdata;
                ones_count <= next_ones;
            end
        end
    end

    // ----------------------------------------------------------------
    // Per-phase correction
    // ----------------------------------------------------------------
    mcr_phase_cal u_cal_a (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .raw_i     (raw_a_i),
        .ap_gain_i (cal_reg[4]),
        .v_gain_i  (cal_reg[7]),
        .i_os_i    (ab_irms_os_i),
        .v_os_i    (cal_reg[1]),
        .cal_o     (cal_a_o)
    );
    mcr_phase_cal u_cal_b (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .raw_i     (raw_b_i),
        .ap_gain_i (cal_reg[5]),
        .v_gain_i  (cal_reg[8]),
        .i_os_i    (ab_irms_os_i),
        .v_os_i    (cal_reg[2]),
        .cal_o     (cal_b_o)
    );
    mcr_phase_cal u_cal_c (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .raw_i     (raw_c_i),
        .ap_gain_i (cal_reg[6]),
        .v_gain_i  (cal_reg[9]),
        .i_os_i    (cal_reg[0]),
        .v_os_i    (cal_reg[3]),
        .cal_o     (cal_c_o)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    ones_capture_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        req_i.rd |=> ones_count == $countones(rdata_o))
        else $error("ones count differs from last read word");
    ro_write_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (req_i.wr && !in_cal) |=> $stable(ones_count) && $stable(die_revision))
        else $error("read-only register changed on write");
    rw_write_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (req_i.wr && req_i.addr == mcr_pkg::ADDR_A_AP_GAIN) |=> cal_reg[4] == $past(req_i.wdata[11:0]))
        else $error("writable register did not take write");
    // Output at this edge was computed from gain and raw values one edge earlier
    unity_gain_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ($past(cal_reg[6]) == 12'h000) |-> cal_c_o.active_pwr == $past(raw_c_i.active_pwr))
        else $error("zero gain does not pass active power");
    va_gain_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ($past(cal_reg[9]) == 12'h000) |-> cal_c_o.apparent_pwr == $past(raw_c_i.apparent_pwr))
        else $error("zero gain does not pass apparent power");
    v_offset_a : assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        cal_c_o.vrms == 24'($past(raw_c_i.vrms) + 24'($signed($past(cal_reg[3])))))
        else $error("voltage rms offset not applied");
endmodule : mcr_reg_tail
`default_nettype wire
